// file: led_disp_pkg.sv
// shared constants and types for the led matrix display link
// How it works
// - shift on each falling clock edge
// - serial out is char four bit seven
// - row driver on when location holds one
// - one strobe lights that column everywhere
// - load char four first, then three two one
// - strobe each column after load, five total
// - 2 ms slot per column refresh
// - shift clock no faster than 3 MHz
// - brightness high or pulse width modulated
// - cascade serial out to next input
// - drop strobe before next column load
package led_disp_pkg;
  localparam int ROWS          = 7;
  localparam int CHARS         = 4;
  localparam int COLS          = 5;
  localparam int SR_BITS       = ROWS * CHARS;
  localparam int CLK_HZ        = 50000000;
  localparam int SCLK_MAX_HZ   = 3000000;
  localparam int SCLK_HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int SLOT_US       = 2000;
  localparam int SLOT_CYC      = CLK_HZ / 1000000 * SLOT_US;
  localparam int BRIGHT_STEPS  = 16;
  localparam int BUF_DEPTH     = 2;
  localparam int SYNC_STAGES   = 3;
  localparam logic [SR_BITS-1:0] SR_RESET = 28'h0000000;
  typedef logic [SR_BITS-1:0] column_word_t;
  typedef enum {ST_IDLE, ST_SHIFT_LO, ST_SHIFT_HI, ST_STROBE} ctl_state_t;
endpackage

// file: led_disp_if.sv
// link between display controller and display module
`timescale 1ns/100ps
interface led_disp_if;
  logic       sclk;
  logic       sdata;
  logic       sout;
  logic [4:0] column_strobe;
  logic       brightness_input;
  modport ctl (output sclk, output sdata, output column_strobe, output brightness_input, input sout);
  modport disp (input sclk, input sdata, input column_strobe, input brightness_input, output sout);
endinterface

// file: led_disp_module.sv
// display module: 28-bit shift register with row drivers
`timescale 1ns/100ps
module led_disp_module
  import led_disp_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  // link
  led_disp_if.disp                   link,
  // lit leds, column-major per row driver
  output logic [COLS-1:0][SR_BITS-1:0] led_on_out,
  output logic [SR_BITS-1:0]         row_drive_out
);
  logic [SYNC_STAGES-1:0] sclk_sync;
  logic [SYNC_STAGES-1:0] sdata_sync;
  logic [SYNC_STAGES-1:0] bright_sync;
  logic                   sclk_level;
  logic                   next_sclk_level;
  column_word_t           sr;
  column_word_t           next_sr;
  logic                   sout;
  logic                   next_sout;
  logic [COLS-1:0][SR_BITS-1:0] next_led_on;
  column_word_t           next_row_drive;

  always_comb begin
    next_sclk_level = sclk_level;
    if (sclk_sync[2] == sclk_sync[1]) begin
      next_sclk_level = sclk_sync[2];
    end
    next_sr = sr;
    if (sclk_level && !next_sclk_level) begin
      next_sr = {sr[SR_BITS-2:0], sdata_sync[2]};
    end
    next_sout = next_sr[SR_BITS-1];
    next_row_drive = bright_sync[2] ? sr : '0;
    for (int c = 0; c < COLS; c++) begin
      next_led_on[c] = link.column_strobe[c] ? next_row_drive : '0;
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_sync     <= '0;
      sdata_sync    <= '0;
      bright_sync   <= '0;
      sclk_level    <= 1'b0;
      sr            <= SR_RESET;
      sout          <= 1'b0;
      row_drive_out <= '0;
      led_on_out    <= '0;
    end else begin
      sclk_sync     <= {sclk_sync[1:0], link.sclk};
      sdata_sync    <= {sdata_sync[1:0], link.sdata};
      bright_sync   <= {bright_sync[1:0], link.brightness_input};
      sclk_level    <= next_sclk_level;
      sr            <= next_sr;
      sout          <= next_sout;
      row_drive_out <= next_row_drive;
      led_on_out    <= next_led_on;
    end
  end

  assign link.sout = sout;
endmodule // led_disp_module

// file: led_disp_ctl.sv
// display controller: buffers column words, shifts them out, strobes columns
`timescale 1ns/100ps
module led_disp_ctl
  import led_disp_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC
)(
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         nrst_in,
  // column word stream, char four rows in top bits
  input  wire logic         word_valid_in,
  input  wire column_word_t word_data_in,
  output logic              word_ready_out,
  // brightness duty, 0..15
  input  wire logic [3:0]   bright_duty_in,
  // status
  output logic [2:0]        column_out,
  output logic              frame_done_out,
  // link
  led_disp_if.ctl           link
);
  column_word_t buf_mem [BUF_DEPTH];
  column_word_t next_buf0;
  column_word_t next_buf1;
  logic [1:0]   buf_cnt;
  logic [1:0]   next_buf_cnt;
  ctl_state_t   state;
  ctl_state_t   next_state;
  column_word_t shreg;
  column_word_t next_shreg;
  logic [4:0]   bit_cnt;
  logic [4:0]   next_bit_cnt;
  logic [31:0]  tmr;
  logic [31:0]  next_tmr;
  logic [2:0]   col;
  logic [2:0]   next_col;
  logic [3:0]   pwm;
  logic         sclk;
  logic         next_sclk;
  logic         sdata;
  logic         next_sdata;
  logic [4:0]   strobe;
  logic [4:0]   next_strobe;
  logic         bright;
  logic         next_bright;
  logic         done;
  logic         next_done;
  logic         pop;

  always_comb begin
    pop          = 1'b0;
    next_state   = state;
    next_shreg   = shreg;
    next_bit_cnt = bit_cnt;
    next_tmr     = tmr + 32'h00000001;
    next_col     = col;
    next_sclk    = sclk;
    next_sdata   = sdata;
    next_strobe  = strobe;
    next_done    = 1'b0;
    next_bright  = (pwm < bright_duty_in) || (bright_duty_in == 4'hF);
    case (state)
      ST_IDLE: begin
        if (buf_cnt != 2'h0) begin
          pop          = 1'b1;
          next_shreg   = buf_mem[0];
          next_bit_cnt = 5'h00;
          next_tmr     = 32'h00000000;
          next_sclk    = 1'b1;
          next_strobe  = '0;
          next_sdata   = buf_mem[0][SR_BITS-1];
          next_state   = ST_SHIFT_HI;
        end
      end
      ST_SHIFT_HI: begin
        if (tmr >= 32'(SCLK_HALF_CYC - 1)) begin
          next_tmr   = 32'h00000000;
          next_sclk  = 1'b0;
          next_state = ST_SHIFT_LO;
        end
      end
      ST_SHIFT_LO: begin
        if (tmr >= 32'(SCLK_HALF_CYC - 1)) begin
          next_tmr = 32'h00000000;
          if (bit_cnt == 5'(SR_BITS - 1)) begin
            next_strobe[col] = 1'b1;
            next_state       = ST_STROBE;
          end else begin
            next_bit_cnt = bit_cnt + 5'h01;
            next_shreg   = {shreg[SR_BITS-2:0], 1'b0};
            next_sdata   = shreg[SR_BITS-2];
            next_sclk    = 1'b1;
            next_state   = ST_SHIFT_HI;
          end
        end
      end
      ST_STROBE: begin
        if (tmr >= 32'(SLOT_CYCLES - 2 * SCLK_HALF_CYC * SR_BITS)) begin
          next_strobe = '0;
          next_state  = ST_IDLE;
          if (col == 3'(COLS - 1)) begin
            next_col  = 3'h0;
            next_done = 1'b1;
          end else begin
            next_col = col + 3'h1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_buf_cnt = buf_cnt - {1'b0, pop} + {1'b0, word_valid_in && word_ready_out};
    next_buf0 = pop ? buf_mem[1] : buf_mem[0];
    next_buf1 = buf_mem[1];
    if (word_valid_in && word_ready_out) begin
      if ((buf_cnt - {1'b0, pop}) == 2'h0) begin
        next_buf0 = word_data_in;
      end else begin
        next_buf1 = word_data_in;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      buf_mem[0]     <= SR_RESET;
      buf_mem[1]     <= SR_RESET;
      buf_cnt        <= 2'h0;
      word_ready_out <= 1'b0;
      state          <= ST_IDLE;
      shreg          <= SR_RESET;
      bit_cnt        <= 5'h00;
      tmr            <= 32'h00000000;
      col            <= 3'h0;
      pwm            <= 4'h0;
      sclk           <= 1'b1;
      sdata          <= 1'b0;
      strobe         <= '0;
      bright         <= 1'b0;
      done           <= 1'b0;
      column_out     <= 3'h0;
      frame_done_out <= 1'b0;
    end else begin
      buf_mem[0]     <= next_buf0;
      buf_mem[1]     <= next_buf1;
      buf_cnt        <= next_buf_cnt;
      word_ready_out <= next_buf_cnt < 2'(BUF_DEPTH);
      state          <= next_state;
      shreg          <= next_shreg;
      bit_cnt        <= next_bit_cnt;
      tmr            <= next_tmr;
      col            <= next_col;
      pwm            <= pwm + 4'h1;
      sclk           <= next_sclk;
      sdata          <= next_sdata;
      strobe         <= next_strobe;
      bright         <= next_bright;
      done           <= next_done;
      column_out     <= next_col;
      frame_done_out <= next_done;
    end
  end

  assign link.sclk             = sclk;
  assign link.sdata            = sdata;
  assign link.column_strobe    = strobe;
  assign link.brightness_input = bright;
endmodule // led_disp_ctl

// file: led_disp_checker.sv
// assertions on the display link
`timescale 1ns/100ps
module led_disp_checker #(
  parameter int SLOT_CYCLES = 100000
)(
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  input wire logic       sclk,
  input wire logic       sdata,
  input wire logic       sout,
  input wire logic [4:0] column_strobe,
  input wire logic       brightness_input
);
  logic        sclk_q;
  logic [7:0]  falls;
  logic [7:0]  gap;
  logic [31:0] on_cnt;
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_q <= 1'b1;
      falls  <= 8'h00;
      gap    <= 8'hFF;
      on_cnt <= 32'h0;
    end else begin
      sclk_q <= sclk;
      falls  <= (|column_strobe) ? 8'h00 : falls + 8'((sclk_q & ~sclk));
      gap    <= (sclk_q & ~sclk) ? 8'h00 : (gap == 8'hFF ? gap : gap + 8'h01);
      on_cnt <= (|column_strobe) ? on_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  a_strobe_one_hot: assert property ($onehot0(column_strobe)) else $error("strobes overlap");
  a_strobe_no_shift: assert property (|column_strobe && |$past(column_strobe) |-> $stable(sclk))
    else $error("shift during strobe");
  a_sclk_low_time: assert property ($fell(sclk) |=> !sclk [*8]) else $error("short low");
  a_sclk_high_time: assert property ($rose(sclk) |=> sclk [*8]) else $error("short high");
  a_sout_after_fall: assert property ($changed(sout) |-> gap < 8'd8) else $error("sout moved");
  a_load_then_strobe: assert property ($rose(|column_strobe) |-> falls == 8'd28) else $error("bad load");
  a_strobe_in_slot: assert property (on_cnt <= 32'(SLOT_CYCLES)) else $error("strobe too long");
  a_strobe_drop_first: assert property (|$past(column_strobe) && |column_strobe
    |-> column_strobe == $past(column_strobe)) else $error("strobe moved");
endmodule // led_disp_checker

// file: led_matrix_shift_display_tb.sv
// testbench joining controller and display module
`timescale 1ns/100ps
module led_matrix_shift_display_tb;
  import led_disp_pkg::*;
  localparam int SLOT = 600;
  logic                         core_clk_in = 1'b0;
  logic                         nrst_in = 1'b0;
  logic                         word_valid_in = 1'b0;
  column_word_t                 word_data_in = SR_RESET;
  logic                         word_ready_out;
  logic [3:0]                   bright_duty_in = 4'hF;
  logic [COLS-1:0][SR_BITS-1:0] led_on_out;
  column_word_t                 row_drive_out;
  logic                         stalled;
  logic [2:0]                   column_out;
  logic                         frame_done_out;
  int                           fail_count = 0;
  int                           check_count = 0;
  int                           cycles = 0;
  led_disp_if link ();
  led_disp_ctl #(.SLOT_CYCLES(SLOT)) u_led_disp_ctl (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .word_valid_in(word_valid_in), .word_data_in(word_data_in), .word_ready_out(word_ready_out),
    .bright_duty_in(bright_duty_in), .column_out(column_out), .frame_done_out(frame_done_out), .link(link.ctl));
  led_disp_module u_led_disp_module (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .link(link.disp),
    .led_on_out(led_on_out), .row_drive_out(row_drive_out));
  led_disp_checker #(.SLOT_CYCLES(SLOT)) u_led_disp_checker (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .sclk(link.sclk), .sdata(link.sdata), .sout(link.sout), .column_strobe(link.column_strobe),
    .brightness_input(link.brightness_input));
  always #10 core_clk_in = ~core_clk_in;
  task automatic print_verdict();
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  task automatic check(input logic [SR_BITS-1:0] seen, input logic [SR_BITS-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send_word(input column_word_t w);
    int n;
    n = 0;
    word_valid_in = 1'b1;
    word_data_in = w;
    while (word_ready_out !== 1'b1 && n < 5000) begin
      stalled = 1'b1;
      @(negedge core_clk_in);
      n++;
    end
    @(negedge core_clk_in);
  endtask
  task automatic run_frame(input logic [3:0] duty, input column_word_t base, input logic lit);
    column_word_t w [COLS];
    int n;
    for (int c = 0; c < COLS; c++) w[c] = base + SR_BITS'(c) * 28'h1234567;
    bright_duty_in = duty;
    stalled = 1'b0;
    fork
      begin
        for (int c = 0; c < COLS; c++) send_word(w[c]);
        word_valid_in = 1'b0;
      end
      for (int c = 0; c < COLS; c++) begin
        n = 0;
        while (link.column_strobe[c] !== 1'b1 && n < 5000) begin
          @(negedge core_clk_in);
          n++;
        end
        repeat (4) @(negedge core_clk_in);
        check(led_on_out[c], lit ? w[c] : SR_RESET);
        check(row_drive_out, lit ? w[c] : SR_RESET);
        check({27'h0, link.sout}, {27'h0, w[c][SR_BITS-1]});
        check({25'h0, column_out}, 28'(c));
      end
    join
    check({27'h0, stalled}, 28'h1);
    n = 0;
    while (frame_done_out !== 1'b1 && n < 400) begin
      @(negedge core_clk_in);
      n++;
    end
    check({27'h0, frame_done_out}, 28'h1);
  endtask
  task automatic check_duty(input logic [3:0] duty);
    int hi;
    hi = 0;
    bright_duty_in = duty;
    repeat (8) @(negedge core_clk_in);
    repeat (64) begin
      @(negedge core_clk_in);
      if (link.brightness_input === 1'b1) hi++;
    end
    check(28'(hi), 28'(duty) * 28'h4);
  endtask
  initial begin
    repeat (20) @(negedge core_clk_in);
    check(row_drive_out, SR_RESET);
    nrst_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    check_duty(4'h5);
    run_frame(4'hF, 28'h8D2E5A1, 1'b1);
    run_frame(4'h0, 28'h5B17C3E, 1'b0);
    print_verdict();
  end
endmodule // led_matrix_shift_display_tb
